// ==== core/upl_pkg.sv ====
// constants and types shared by the line and host control block
`default_nettype none
package upl_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_MODEM_CTRL = 6'h00;
  localparam logic [5:0] OFS_INT_ENABLE = 6'h04;
  localparam logic [5:0] OFS_ENH_FEATURE = 6'h08;
  localparam logic [5:0] OFS_EXT_FEATURE = 6'h0C;
  localparam logic [5:0] OFS_DIVISOR = 6'h10;
  localparam logic [5:0] OFS_DATA = 6'h14;
  localparam logic [5:0] OFS_LINE_STATUS = 6'h18;
  localparam logic [5:0] OFS_INT_STATUS = 6'h1C;
  localparam logic [5:0] OFS_INT_MASK = 6'h20;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_IRQ_EN = 3;
  localparam int MCR_IR_MODE = 4;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_AUTO_CTS = 7;
  localparam int XFR_RS485 = 2;
  localparam int XFR_RS485_INV = 5;
  localparam int EV_RX_READY = 0;
  localparam int EV_TX_DONE = 1;
  localparam int EV_RTS_OFF = 6;
  localparam int EV_CTS_CHANGE = 7;
  // ---------------------------------------------------------------
  // reset values, address decode and bit timing
  // ---------------------------------------------------------------
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h0001;
  localparam logic [9:0] PRINTER_PORT1_DECODE_N_BASE = 10'h378;
  localparam logic [9:0] PRINTER_PORT2_DECODE_N_BASE = 10'h278;
  localparam logic [9:0] COM1_BASE = 10'h3F8;
  localparam logic [9:0] COM2_BASE = 10'h2F8;
  localparam logic [9:0] COM3_BASE = 10'h3E8;
  localparam logic [9:0] COM4_BASE = 10'h2E8;
  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [4:0] IR_HOLD_TICKS = 5'h10;
  // ---------------------------------------------------------------
  // shifter states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } upl_state_t;
endpackage : upl_pkg
`default_nettype wire

// ==== core/upl_tx.sv ====
// serial transmit shifter, 8 data bits, one stop bit
`default_nettype none
module upl_tx
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic tick16,
  input wire logic start,
  input wire logic [7:0] data,
  // status and line
  output logic busy,
  output logic done,
  output logic serial,
  output logic [3:0] phase
);
  import upl_pkg::*;
  upl_state_t state_r;
  logic [3:0] sub_r;
  logic [2:0] bitIdx_r;
  logic [7:0] shift_r;
  wire bitEnd = tick16 && (sub_r == 4'hF);
  assign busy = (state_r != ST_IDLE);
  assign done = bitEnd && (state_r == ST_STOP);
  assign phase = sub_r;
  assign serial = (state_r == ST_START) ? 1'b0 : (state_r == ST_DATA) ? shift_r[0] : 1'b1;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_IDLE;
      sub_r <= 4'h0;
      bitIdx_r <= 3'h0;
      shift_r <= 8'h00;
    end
    else if (state_r == ST_IDLE)
    begin
      sub_r <= 4'h0;
      if (start)
      begin
        shift_r <= data;
        state_r <= ST_START;
      end
    end
    else
    begin
      if (tick16)
        sub_r <= sub_r + 4'h1;
      if (bitEnd)
      begin
        unique case (state_r)
          ST_START: state_r <= ST_DATA;
          ST_DATA:
          begin
            shift_r <= {1'b0, shift_r[7:1]};
            bitIdx_r <= bitIdx_r + 3'h1;
            if (bitIdx_r == 3'h7)
              state_r <= ST_STOP;
          end
          ST_STOP: state_r <= ST_IDLE;
          ST_IDLE: state_r <= ST_IDLE;
        endcase
      end
    end
  end
endmodule : upl_tx
`default_nettype wire

// ==== core/upl_rx.sv ====
// serial receive sampler, idle high input, mid-bit sampling
`default_nettype none
module upl_rx
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // line
  input wire logic tick16,
  input wire logic din,
  // result
  output logic valid,
  output logic [7:0] data
);
  import upl_pkg::*;
  upl_state_t state_r;
  logic [3:0] sub_r;
  logic [2:0] bitIdx_r;
  logic [7:0] shift_r;
  wire sample = tick16 && (sub_r == MID_TICK);
  assign data = shift_r;
  assign valid = sample && (state_r == ST_STOP) && din;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_IDLE;
      sub_r <= 4'h0;
      bitIdx_r <= 3'h0;
      shift_r <= 8'h00;
    end
    else if (state_r == ST_IDLE)
    begin
      sub_r <= 4'h0;
      bitIdx_r <= 3'h0;
      if (tick16 && !din)
        state_r <= ST_START;
    end
    else
    begin
      if (tick16)
        sub_r <= sub_r + 4'h1;
      if (sample)
      begin
        unique case (state_r)
          ST_START: state_r <= din ? ST_IDLE : ST_DATA;
          ST_DATA:
          begin
            shift_r <= {din, shift_r[7:1]};
            bitIdx_r <= bitIdx_r + 3'h1;
            if (bitIdx_r == 3'h7)
              state_r <= ST_STOP;
          end
          ST_STOP: state_r <= ST_IDLE;
          ST_IDLE: state_r <= ST_IDLE;
        endcase
      end
    end
  end
endmodule : upl_rx
`default_nettype wire

// ==== core/upl_core.sv ====
// host decode, interrupt routing and serial line control
// Notes on behaviour
// RULE1 - with address enable low, decode host address as the selected COM port
// RULE2 - the three port selects choose COM address and interrupt request line; the code takes the COM address from portSelectA and portSelectB only
// RULE3 - request lines active high, driven only with modem bit 3 and sources enabled
// RULE4 - in PC mode flag host accesses to the first printer port range, low
// RULE5 - in PC mode the receiver runs from the internal baud generator tick
// RULE6 - in PC mode flag host accesses to the second printer port range, low
// RULE7 - transmit is active low when wired, active high pulses in infrared
// RULE8 - infrared mode comes from the strap at reset or a software bit
// RULE9 - receive idles high wired, low infrared; infrared pulses are decoded
// RULE10 - outside circuit holds receive at the idle level of the mode
// RULE11 - request-to-send does auto flow control or RS485 direction control
// RULE12 - auto request-to-send starts only after the pin was asserted once
// RULE13 - with auto clear-to-send, transmit stops while clear-to-send is off
// RULE14 - terminal-ready output is active low and general purpose
// RULE15 - data-set-ready input is active low and general purpose
// RULE16 - PC mode is chosen by both mode pins tied low
// RULE17 - extra host address lines feed the COM and printer decoder
// RULE18 - a character in flight completes before the transmitter halts
`default_nettype none
module upl_core
#(
  parameter logic [15:0] DIVISOR_DEFAULT = upl_pkg::DIVISOR_RESET
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // avalon register slave
  input wire logic [5:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  output logic irqOut,
  // pc host pins
  input wire logic [9:0] hostAddr,
  input wire logic hostAddrValid_n,
  input wire logic portSelectA,
  input wire logic portSelectB,
  input wire logic portSelectC,
  input wire logic pcModeSel_n,
  input wire logic busInterfaceMode_n,
  output logic comSelect,
  output logic intRequestLineA,
  output logic intRequestLineAOe,
  output logic intRequestLineB,
  output logic intRequestLineBOe,
  output logic intRequestLineC,
  output logic intRequestLineCOe,
  output logic printerPort1Decode_n,
  output logic printerPort2Decode_n,
  output logic baudGenClockOut_n,
  input wire logic rcvClk,
  // serial line pins
  input wire logic infraredStrap,
  output logic txPin,
  input wire logic rxPin,
  output logic rtsPin_n,
  input wire logic ctsPin_n,
  output logic dtrPin_n,
  input wire logic dsrPin_n
);
  import upl_pkg::*;
  // ---------------------------------------------------------------
  // decode functions
  // ---------------------------------------------------------------
  function automatic logic [9:0] comBase(input logic [1:0] sel);
    unique case (sel)
      2'b00: comBase = COM1_BASE;
      2'b01: comBase = COM2_BASE;
      2'b10: comBase = COM3_BASE;
      2'b11: comBase = COM4_BASE;
    endcase
  endfunction : comBase
  function automatic logic rangeHit(input logic [9:0] addr, input logic [9:0] base);
    rangeHit = (addr[9:3] == base[9:3]);
  endfunction : rangeHit
  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  logic [7:0] mcr_r, ier_r, efr_r, xfr_r, intStat_r, intMask_r, intStat_nxt;
  logic [15:0] divisor_r, baudCnt_r;
  logic [7:0] txHold_r, rxHold_r;
  logic txPend_r, rxFull_r, strapIr_r, strapDone_r, rtsArmed_r, ctsPrev_r;
  logic baudTick_r, rcvClkPrev_r;
  logic [4:0] irHold_r;
  logic [2:0] lineSel_r;
  // ---------------------------------------------------------------
  // mode and host decode
  // ---------------------------------------------------------------
  wire pcMode = !pcModeSel_n && !busInterfaceMode_n; // RULE16
  wire [2:0] sel = {portSelectC, portSelectB, portSelectA};
  wire addrOn = pcMode && !hostAddrValid_n;
  wire comHit = addrOn && rangeHit(hostAddr, comBase(sel[1:0])); // RULE1 RULE17
  wire lpt1Hit = addrOn && rangeHit(hostAddr, PRINTER_PORT1_DECODE_N_BASE); // RULE4 RULE17
  wire lpt2Hit = addrOn && rangeHit(hostAddr, PRINTER_PORT2_DECODE_N_BASE); // RULE6 RULE17
  wire [2:0] lineSel = (sel == 3'h7) ? 3'b100 : sel[0] ? 3'b010 : 3'b001; // RULE2
  wire irqPend = |(intStat_r & ier_r);
  wire irqDrive = pcMode && mcr_r[MCR_IRQ_EN] && (|ier_r); // RULE3
  // ---------------------------------------------------------------
  // baud generator and receive clock
  // ---------------------------------------------------------------
  wire baudWrap = (baudCnt_r >= divisor_r - 16'h0001);
  wire rcvClkEdge = rcvClk && !rcvClkPrev_r;
  wire rxTick = pcMode ? baudTick_r : rcvClkEdge; // RULE5
  // ---------------------------------------------------------------
  // serial datapath
  // ---------------------------------------------------------------
  wire irMode = strapIr_r || mcr_r[MCR_IR_MODE]; // RULE8
  wire ctsOn = !ctsPin_n;
  wire ctsOk = !efr_r[EFR_AUTO_CTS] || ctsOn; // RULE13
  logic txBusy, txDone, txSerial, rxValid;
  logic [3:0] txPhase;
  logic [7:0] rxData;
  wire txStart = txPend_r && !txBusy && ctsOk; // RULE18
  wire txLine = irMode ? (!txSerial && (txPhase < IR_PULSE_TICKS)) : txSerial; // RULE7
  wire rxNorm = irMode ? (irHold_r == 5'h00) && !rxPin : rxPin; // RULE9
  upl_tx u_tx
  (
    .clk(clk),
    .arst_n(arst_n),
    .tick16(baudTick_r),
    .start(txStart),
    .data(txHold_r),
    .busy(txBusy),
    .done(txDone),
    .serial(txSerial),
    .phase(txPhase)
  );
  upl_rx u_rx
  (
    .clk(clk),
    .arst_n(arst_n),
    .tick16(rxTick),
    .din(rxNorm),
    .valid(rxValid),
    .data(rxData)
  );
  // ---------------------------------------------------------------
  // request-to-send control
  // ---------------------------------------------------------------
  wire autoRts = efr_r[EFR_AUTO_RTS] && mcr_r[MCR_RTS] && rtsArmed_r; // RULE12
  wire rs485Act = txBusy || txPend_r;
  wire rtsAct = xfr_r[XFR_RS485] ? (rs485Act ^ xfr_r[XFR_RS485_INV]) : // RULE11
    autoRts ? !rxFull_r : mcr_r[MCR_RTS];
  // ---------------------------------------------------------------
  // bus access decode
  // ---------------------------------------------------------------
  wire busAct = (avsRead || avsWrite) && !avsWaitRequest;
  wire wrOn = busAct && avsWrite;
  wire rdData = busAct && avsRead && (avsAddress == OFS_DATA);
  wire wrData = wrOn && (avsAddress == OFS_DATA) && !txPend_r;
  wire [7:0] w8 = avsWriteData[7:0];
  wire [7:0] lineStat = {1'b0, comHit, pcMode, irMode, !dsrPin_n, ctsOn, txBusy, rxFull_r}; // RULE15
  wire ctsEdge = strapDone_r && (ctsPin_n != ctsPrev_r);
  wire [7:0] events = {ctsEdge, autoRts && rxValid, 4'h0, txDone, rxValid};
  wire [7:0] w1c = (wrOn && avsAddress == OFS_INT_STATUS) ? w8 : 8'h00;
  assign intStat_nxt = (intStat_r & ~w1c) | events;
  logic [31:0] rdMux;
  always_comb
  begin
    unique case (avsAddress)
      OFS_MODEM_CTRL: rdMux = {24'h0, mcr_r};
      OFS_INT_ENABLE: rdMux = {24'h0, ier_r};
      OFS_ENH_FEATURE: rdMux = {24'h0, efr_r};
      OFS_EXT_FEATURE: rdMux = {24'h0, xfr_r};
      OFS_DIVISOR: rdMux = {16'h0, divisor_r};
      OFS_DATA: rdMux = {24'h0, rxHold_r};
      OFS_LINE_STATUS: rdMux = {24'h0, lineStat};
      OFS_INT_STATUS: rdMux = {24'h0, intStat_r};
      OFS_INT_MASK: rdMux = {24'h0, intMask_r};
      default: rdMux = 32'h0;
    endcase
  end
  // ---------------------------------------------------------------
  // bus slave and configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h0;
      mcr_r <= MCR_RESET;
      ier_r <= 8'h00;
      efr_r <= 8'h00;
      xfr_r <= 8'h00;
      intMask_r <= 8'h00;
      divisor_r <= DIVISOR_RESET;
    end
    else
    begin
      avsWaitRequest <= !((avsRead || avsWrite) && avsWaitRequest);
      if ((avsRead || avsWrite) && avsWaitRequest)
        avsReadData <= rdMux;
      if (wrOn && avsAddress == OFS_MODEM_CTRL)
        mcr_r <= w8;
      if (wrOn && avsAddress == OFS_INT_ENABLE)
        ier_r <= w8;
      if (wrOn && avsAddress == OFS_ENH_FEATURE)
        efr_r <= w8;
      if (wrOn && avsAddress == OFS_EXT_FEATURE)
        xfr_r <= w8;
      if (wrOn && avsAddress == OFS_INT_MASK)
        intMask_r <= w8;
      if (wrOn && avsAddress == OFS_DIVISOR)
        divisor_r <= (avsWriteData[15:0] == 16'h0) ? DIVISOR_DEFAULT : avsWriteData[15:0];
    end
  end
  // ---------------------------------------------------------------
  // datapath state
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      baudCnt_r <= 16'h0;
      baudTick_r <= 1'b0;
      rcvClkPrev_r <= 1'b0;
      txPend_r <= 1'b0;
      txHold_r <= 8'h00;
      rxFull_r <= 1'b0;
      rxHold_r <= 8'h00;
      irHold_r <= 5'h00;
      intStat_r <= 8'h00;
      ctsPrev_r <= 1'b1;
      rtsArmed_r <= 1'b0;
      strapDone_r <= 1'b0;
      strapIr_r <= 1'b0;
    end
    else
    begin
      baudCnt_r <= baudWrap ? 16'h0 : baudCnt_r + 16'h0001;
      baudTick_r <= baudWrap;
      rcvClkPrev_r <= rcvClk;
      strapDone_r <= 1'b1;
      if (!strapDone_r)
        strapIr_r <= infraredStrap; // RULE8
      if (wrData)
      begin
        txHold_r <= w8;
        txPend_r <= 1'b1;
      end
      else if (txStart)
        txPend_r <= 1'b0;
      if (rxValid)
      begin
        rxHold_r <= rxData;
        rxFull_r <= 1'b1;
      end
      else if (rdData)
        rxFull_r <= 1'b0;
      if (irMode && rxPin)
        irHold_r <= IR_HOLD_TICKS; // RULE9
      else if (rxTick && irHold_r != 5'h00)
        irHold_r <= irHold_r - 5'h01;
      intStat_r <= intStat_nxt;
      ctsPrev_r <= ctsPin_n;
      if (!rtsPin_n)
        rtsArmed_r <= 1'b1; // RULE12
    end
  end
  // ---------------------------------------------------------------
  // registered pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqOut <= 1'b0;
      comSelect <= 1'b0;
      lineSel_r <= 3'b000;
      {intRequestLineA, intRequestLineB, intRequestLineC} <= 3'b000;
      {intRequestLineAOe, intRequestLineBOe, intRequestLineCOe} <= 3'b000;
      printerPort1Decode_n <= 1'b1;
      printerPort2Decode_n <= 1'b1;
      baudGenClockOut_n <= 1'b1;
      txPin <= 1'b1;
      rtsPin_n <= 1'b1;
      dtrPin_n <= 1'b1;
    end
    else
    begin
      irqOut <= |(intStat_nxt & intMask_r);
      comSelect <= comHit; // RULE1
      lineSel_r <= lineSel;
      {intRequestLineC, intRequestLineB, intRequestLineA} <= lineSel & {3{irqPend}}; // RULE3
      {intRequestLineCOe, intRequestLineBOe, intRequestLineAOe} <= lineSel & {3{irqDrive}};
      printerPort1Decode_n <= !lpt1Hit; // RULE4
      printerPort2Decode_n <= !lpt2Hit; // RULE6
      if (baudWrap)
        baudGenClockOut_n <= !baudGenClockOut_n;
      txPin <= txLine; // RULE7
      rtsPin_n <= !rtsAct; // RULE11
      dtrPin_n <= !mcr_r[MCR_DTR]; // RULE14
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_com_decode: assert property (addrOn && rangeHit(hostAddr, comBase(sel[1:0])) |=> comSelect) // RULE1
    else $error("com port access not flagged");
  a_irq_line_pick: assert property (intRequestLineCOe |-> $past(sel) == 3'h7) // RULE2
    else $error("line c driven for wrong select");
  a_irq_gate: assert property (intRequestLineAOe |-> $past(pcMode && mcr_r[MCR_IRQ_EN])) // RULE3
    else $error("request line driven without enable");
  a_printer_port1_decode_n_flag: assert property (!printerPort1Decode_n |-> $past(pcMode && !hostAddrValid_n)) // RULE4
    else $error("printer 1 flag outside pc access");
  a_printer_port2_decode_n_flag: assert property (lpt2Hit |=> !printerPort2Decode_n) // RULE6
    else $error("printer 2 access not flagged");
  a_ir_idle: assert property (irMode && !txBusy && $stable(irMode) |=> !txPin) // RULE7
    else $error("infrared transmit not idle low");
  a_cts_hold: assert property (efr_r[EFR_AUTO_CTS] && ctsPin_n && !txBusy |=> !txBusy) // RULE13
    else $error("transmit started with clear-to-send off");
  a_dtr_follow: assert property ($rose(mcr_r[MCR_DTR]) |=> !dtrPin_n) // RULE14
    else $error("terminal-ready not asserted");
  a_rts_manual: assert property (!xfr_r[XFR_RS485] && !rtsArmed_r && mcr_r[MCR_RTS] |=> !rtsPin_n) // RULE12
    else $error("manual request-to-send not driven");
  a_bus_answer: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("bus request not answered in one cycle");
  a_irq_route: assert property ((intRequestLineAOe || intRequestLineBOe || intRequestLineCOe) // RULE2
    |-> {intRequestLineCOe, intRequestLineBOe, intRequestLineAOe} == lineSel_r)
    else $error("request line differs from select");
  c_pc_irq: cover property (intRequestLineAOe && intRequestLineA);
  c_tx_char: cover property (txDone);
  c_rx_char: cover property (rxValid && irMode);
endmodule : upl_core
`default_nettype wire

// ==== tb/upl_line_model.sv ====
// far end of the serial line: drives receive data and modem inputs, decodes transmit data
`default_nettype none
module upl_line_model
(
  // clock
  input wire logic clk,
  // line
  input wire logic txPin,
  input wire logic irMode,
  output logic rxPin,
  output logic ctsPin_n,
  output logic dsrPin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    rxPin = 1'h1;
    ctsPin_n = 1'h0;
    dsrPin_n = 1'h1;
  end
  // park receive data at the idle level of the mode
  always @(irMode)
    rxPin <= !irMode;
  // one 8n1 character, lsb first, 16 clocks a bit; infrared sends a short pulse per 0 bit
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      rxPin <= irMode ? !f[i] : f[i];
      repeat (irMode ? 3 : 16) @(posedge clk);
      if (irMode)
      begin
        rxPin <= 1'h0;
        repeat (13) @(posedge clk);
      end
    end
  endtask : send
  // catch one character from transmit data, mid-bit sampling
  task automatic recv(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    d = 8'h00;
    ok = 1'h0;
    while (txPin !== 1'h0 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    if (n < 400)
    begin
      repeat (8) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (16) @(posedge clk);
        d[i] = txPin;
      end
      repeat (16) @(posedge clk);
      ok = (txPin === 1'h1);
    end
  endtask : recv
endmodule : upl_line_model
`default_nettype wire

// ==== tb/upl_core_tb_top.sv ====
// self-checking bench for host decode, request routing and serial line control
`default_nettype none
module upl_core_tb_top import upl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, avsRead, avsWrite, avsWaitRequest, irqOut, ok;
  logic [5:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, q;
  logic [9:0] hostAddr;
  logic [9:0] comBase [4];
  logic [7:0] b;
  logic hostAddrValid_n, portSelectA, portSelectB, portSelectC, pcModeSel_n;
  logic busInterfaceMode_n, comSelect, intRequestLineA, intRequestLineAOe, intRequestLineB;
  logic intRequestLineBOe, intRequestLineC, intRequestLineCOe, printerPort1Decode_n;
  logic printerPort2Decode_n, baudGenClockOut_n, rcvClk, infraredStrap, txPin, rxPin;
  logic rtsPin_n, ctsPin_n, dtrPin_n, dsrPin_n, irMode;
  int nErrors, nChecks, hi;
  upl_core dut (.clk, .arst_n, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsReadData,
    .avsWaitRequest, .irqOut, .hostAddr, .hostAddrValid_n, .portSelectA, .portSelectB,
    .portSelectC, .pcModeSel_n, .busInterfaceMode_n, .comSelect, .intRequestLineA,
    .intRequestLineAOe, .intRequestLineB, .intRequestLineBOe, .intRequestLineC,
    .intRequestLineCOe, .printerPort1Decode_n, .printerPort2Decode_n, .baudGenClockOut_n,
    .rcvClk, .infraredStrap, .txPin, .rxPin, .rtsPin_n, .ctsPin_n, .dtrPin_n, .dsrPin_n);
  upl_line_model line (.clk, .txPin, .irMode, .rxPin, .ctsPin_n, .dsrPin_n);
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    if (nErrors == 0 && nChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avsWaitRequest !== 1'h0 && n < 50);
    if (n >= 50)
    begin
      chk(32'h0, 32'h1);
      close_out();
    end
    else
    begin
      q = avsReadData;
      avsWrite <= 1'h0;
      avsRead <= 1'h0;
    end
  endtask : bus
  // present a host address with address enable low, let the decode settle
  task automatic host(input logic [9:0] a);
    @(posedge clk);
    hostAddr <= a;
    hostAddrValid_n <= 1'h0;
    repeat (3) @(posedge clk);
  endtask : host
  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'h0;
    forever #5 clk = !clk;
  end
  initial
  begin
    arst_n = 1'h0;
    {avsRead, avsWrite, avsAddress, avsWriteData} = '0;
    hostAddr = 10'h000;
    hostAddrValid_n = 1'h1;
    {portSelectC, portSelectB, portSelectA} = 3'h0;
    pcModeSel_n = 1'h0;
    busInterfaceMode_n = 1'h0;
    rcvClk = 1'h0;
    infraredStrap = 1'h0;
    irMode = 1'h0;
    comBase = '{COM1_BASE, COM2_BASE, COM3_BASE, COM4_BASE};
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    chk(dtrPin_n, 32'h1);
    chk(txPin, 32'h1);
    bus(1'h0, OFS_MODEM_CTRL, 32'h0);
    chk(q, 32'h0);
    bus(1'h0, OFS_DIVISOR, 32'h0);
    chk(q, 32'h1);
    b[0] = baudGenClockOut_n;
    @(posedge clk);
    chk(baudGenClockOut_n, !b[0]);
    bus(1'h0, 6'h3C, 32'h0);
    chk(q, 32'h0);
    bus(1'h1, OFS_MODEM_CTRL, 32'h1);
    line.dsrPin_n <= 1'h0;
    repeat (3) @(posedge clk);
    chk(dtrPin_n, 32'h0);
    bus(1'h0, OFS_LINE_STATUS, 32'h0);
    chk(q[5:3], 3'h5);
    for (int s = 0; s < 4; s++)
    begin
      {portSelectC, portSelectB, portSelectA} <= 3'(s);
      host(comBase[s] + 10'h7);
      chk(comSelect, 32'h1);
      host(comBase[(s + 1) % 4]);
      chk(comSelect, 32'h0);
    end
    hostAddrValid_n <= 1'h1;
    repeat (3) @(posedge clk);
    chk(comSelect, 32'h0);
    host(PRINTER_PORT1_DECODE_N_BASE + 10'h7);
    chk({printerPort1Decode_n, printerPort2Decode_n}, 32'h1);
    host(PRINTER_PORT2_DECODE_N_BASE);
    chk({printerPort1Decode_n, printerPort2Decode_n}, 32'h2);
    hostAddrValid_n <= 1'h1;
    {portSelectC, portSelectB, portSelectA} <= 3'h0;
    bus(1'h1, OFS_INT_ENABLE, 32'h1);
    bus(1'h1, OFS_INT_MASK, 32'h1);
    line.send(8'hA5);
    repeat (3) @(posedge clk);
    chk({irqOut, intRequestLineAOe}, 32'h2);
    bus(1'h1, OFS_MODEM_CTRL, 32'h9);
    repeat (3) @(posedge clk);
    chk({intRequestLineAOe, intRequestLineA}, 32'h3);
    {portSelectC, portSelectB, portSelectA} <= 3'h1;
    repeat (3) @(posedge clk);
    chk({intRequestLineAOe, intRequestLineBOe, intRequestLineB}, 32'h3);
    {portSelectC, portSelectB, portSelectA} <= 3'h7;
    repeat (3) @(posedge clk);
    chk({intRequestLineAOe, intRequestLineCOe, intRequestLineC}, 32'h3);
    bus(1'h0, OFS_DATA, 32'h0);
    chk(q, 32'hA5);
    bus(1'h0, OFS_INT_STATUS, 32'h0);
    chk(q, 32'h1);
    bus(1'h1, OFS_INT_STATUS, 32'h1);
    repeat (3) @(posedge clk);
    chk({irqOut, intRequestLineC}, 32'h0);
    bus(1'h1, OFS_DATA, 32'h3C);
    line.recv(b, ok);
    chk({ok, b}, 32'h13C);
    bus(1'h1, OFS_ENH_FEATURE, 32'h80);
    line.ctsPin_n <= 1'h1;
    bus(1'h1, OFS_DATA, 32'h5A);
    repeat (100) @(posedge clk);
    chk(txPin, 32'h1);
    line.ctsPin_n <= 1'h0;
    fork
      line.recv(b, ok);
      begin
        repeat (60) @(posedge clk);
        line.ctsPin_n <= 1'h1;
      end
    join
    line.ctsPin_n <= 1'h0;
    chk({ok, b}, 32'h15A);
    bus(1'h1, OFS_ENH_FEATURE, 32'h40);
    repeat (3) @(posedge clk);
    chk(rtsPin_n, 32'h1);
    bus(1'h1, OFS_MODEM_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    chk(rtsPin_n, 32'h0);
    line.send(8'h11);
    repeat (3) @(posedge clk);
    chk(rtsPin_n, 32'h1);
    bus(1'h0, OFS_DATA, 32'h0);
    repeat (3) @(posedge clk);
    chk({rtsPin_n, q[7:0]}, 32'h11);
    bus(1'h1, OFS_ENH_FEATURE, 32'h0);
    bus(1'h1, OFS_MODEM_CTRL, 32'h0);
    bus(1'h1, OFS_EXT_FEATURE, 32'h4);
    bus(1'h1, OFS_DATA, 32'h81);
    repeat (20) @(posedge clk);
    chk(rtsPin_n, 32'h0);
    repeat (200) @(posedge clk);
    chk(rtsPin_n, 32'h1);
    bus(1'h1, OFS_EXT_FEATURE, 32'h24);
    repeat (3) @(posedge clk);
    chk(rtsPin_n, 32'h0);
    bus(1'h1, OFS_EXT_FEATURE, 32'h0);
    bus(1'h1, OFS_MODEM_CTRL, 32'h10);
    irMode <= 1'h1;
    repeat (3) @(posedge clk);
    chk(txPin, 32'h0);
    bus(1'h0, OFS_LINE_STATUS, 32'h0);
    chk(q[4], 1'h1);
    bus(1'h1, OFS_DATA, 32'h0);
    hi = 0;
    repeat (180)
    begin
      @(posedge clk);
      hi += int'(txPin === 1'h1);
    end
    chk(32'(hi), 32'(9 * IR_PULSE_TICKS));
    line.send(8'h96);
    bus(1'h0, OFS_DATA, 32'h0);
    chk(q, 32'h96);
    infraredStrap <= 1'h1;
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge clk);
    chk(txPin, 32'h0);
    bus(1'h0, OFS_LINE_STATUS, 32'h0);
    chk(q[4], 1'h1);
    close_out();
  end
endmodule : upl_core_tb_top
`default_nettype wire
